//--- pkg/sps_pkg.sv
package sps_pkg;
    // register byte addresses on apb
    localparam logic [11:0] ADDR_CTRL_ONE = 12'h000;   // power_mgmt_control_one
    localparam logic [11:0] ADDR_CTRL_TWO = 12'h004;   // power_mgmt_control_two
    localparam logic [11:0] ADDR_CFG = 12'h008;        // debug, display, clock, option bits
    localparam logic [11:0] ADDR_STATUS = 12'h00c;     // current mode, debug active and latch state
    localparam logic [11:0] ADDR_PORT = 12'h010;       // port data and direction
    // control one fields
    localparam int LVD_EN_BIT = 0;      // low_voltage_detect_enable
    localparam int LVD_STOP_BIT = 1;    // low_voltage_detect_stop_enable
    localparam int STOP_EN_BIT = 2;     // stop_instruction_enable
    // control two fields
    localparam int PART_PD_BIT = 0;     // partial_power_down_control
    localparam int PD_CTL_BIT = 1;      // power_down_control
    localparam int ACK_BIT = 2;         // power_down_acknowledge, write only
    localparam int PART_FLAG_BIT = 3;   // partial_power_down_flag
    localparam int PD_FLAG_BIT = 4;     // power_down_flag
    // config fields
    localparam int DBG_EN_BIT = 0;      // debug_mode_enable
    localparam int OSC_STOP_BIT = 1;    // oscillator_in_stop_enable
    localparam int LCD_STOP3_BIT = 2;   // display_run_in_stop3
    localparam int ADACK_BIT = 3;       // converter async clock enable
    localparam int RTIEN_BIT = 4;       // periodic_wake_interrupt enable
    // port register layout
    localparam int PORT_W = 8;
    localparam int PORT_DIR_LSB = 8;
    localparam logic [7:0] PORT_RESET = 8'h00;
    typedef enum logic [1:0] {SPS_RUN, SPS_STOP3, SPS_STOP2, SPS_STOP1} sps_mode_t;
endpackage

//--- core/sps_sequencer.sv
// Implementation choices: the address map and register access over APB.
`timescale 1ns/1ns
// What this block does
// - stop disabled gives reset; bits choose mode
// - detector enabled in stop keeps regulator active
// - debug enable keeps debug clock, full regulation
// - status memory commands error while stopped
// - debug background command wakes stop, debug active
// - stop2 powers down, keeps ram, latches pins
// - stop2 exits on wake, reset, irq, periodic
// - irq pin active-low wake in stop2
// - stop1/stop2 wake behaves as power-on reset
// - stop2 wake sets flag, holds latches until ack
// - unrestored port registers give reset pin states
// - released pins without peripheral follow port registers
// - stop1 powers off ram, pins high impedance
// - stop1 exits on irq low, wake, reset, periodic
// - stop1 wake sets power-down flag until ack
// - peripheral clocks halt in every stop mode
// - stop3 converter runs only with async clock, detector
// - stop3 clock generator runs only with oscillator enable
// - stop3 display runs only with its run bit
// - stop3 retains state; exits on reset, interrupts
module sps_sequencer
(
    input wire logic pclk,                    // bus clock
    input wire logic presetn,                 // async reset, active low
    input wire logic psel,                    // apb select
    input wire logic penable,                 // apb access phase
    input wire logic pwrite,                  // apb direction
    input wire logic [11:0] paddr,            // apb byte address
    input wire logic [31:0] pwdata,           // apb write data
    output logic [31:0] prdata,               // apb read data
    output logic pready,                      // apb ready
    output logic pslverr,                     // apb error
    input wire logic stop_exec,               // cpu executes stop, one pulse
    input wire logic wake_pin,                // wake-up pin, active high, async
    input wire logic irq_n_pin,               // external interrupt pin, async
    input wire logic reset_pin_n,             // reset pin, active low, async
    input wire logic rti_tick,                // periodic wake tick, pulse
    input wire logic stop3_irq,               // any stop3 interrupt source, level
    input wire logic dbg_background_cmd,      // debug background command, pulse
    input wire logic dbg_status_cmd,          // memory-with-status command, pulse
    input wire logic [7:0] periph_en,         // per-pin peripheral owns pin
    input wire logic [7:0] periph_out,        // per-pin peripheral output
    input wire logic [7:0] periph_oe,         // per-pin peripheral drive
    output logic illegal_op_reset,            // illegal opcode reset pulse
    output logic por_reset,                   // power-on style reset pulse
    output logic dbg_status_err,              // status command error pulse
    output logic dbg_mem_grant,               // memory access allowed, pulse
    output logic dbg_active,                  // active background mode
    output logic dbg_clk_en,                  // debug logic clock enable
    output logic periph_clk_en,               // peripheral clock enable
    output logic reg_active,                  // regulator fully regulating
    output logic reg_standby,                 // regulator in standby
    output logic ram_power,                   // ram powered
    output logic core_power,                  // main circuitry powered
    output logic adc_run,                     // converter allowed to run
    output logic clkgen_run,                  // clock generator running
    output logic lcd_run,                     // display driver running
    output logic [1:0] stop_mode,             // current mode
    output logic [7:0] pin_out,               // pin output value
    output logic [7:0] pin_oe_n               // pin output enable, low drives
);
    localparam int W = sps_pkg::PORT_W;

    typedef struct packed {
        sps_pkg::sps_mode_t mode;
        // control one
        logic lvd_en;
        logic lvd_stop;
        logic stop_en;

        // control two
        logic part_pd;
        logic pd_ctl;
        logic part_flag;
        logic pd_flag;

        // config
        logic dbg_en;
        logic osc_stop;
        logic lcd_stop3;
        logic adack;
        logic rtien;

        logic lvd_hold;           // detector enabled at stop entry
        logic dbg_hold;           // debug enabled at stop entry
        logic latched;            // pin latches closed
        logic dbg_act;
        logic [W-1:0] port_d;
        logic [W-1:0] port_dd;
        logic [W-1:0] lat_out;
        logic [W-1:0] lat_oe;
        logic ill;
        logic por;
        logic serr;
        logic sgrant;
        logic [2:0] s1;           // synchroniser first stage: wake, irq, reset
        logic [2:0] s2;
        logic [31:0] rdata;
    } sps_state_t;

    sps_state_t r;
    sps_state_t next_r;

    // pin drive without latching: peripheral first, else port registers
    // read every cycle so released pins pick up restored ports
    function automatic logic [2*W-1:0] live_pins(input sps_state_t s, input logic [W-1:0] pe,
                                                 input logic [W-1:0] po, input logic [W-1:0] poe);
        logic [W-1:0] o;
        logic [W-1:0] e;
        o = (pe & po) | (~pe & s.port_d);
        e = (pe & poe) | (~pe & s.port_dd);
        return {e, o};
    endfunction

    logic [2*W-1:0] live;
    logic setup_ok;
    logic access;
    logic wake_s;
    logic irq_low_s;
    logic rst_low_s;

    assign live = live_pins(r, periph_en, periph_out, periph_oe);
    assign access = psel & penable;
    assign setup_ok = 1'b1;
    // only the second stage is read; the first may be metastable
    assign wake_s = r.s2[0];
    assign irq_low_s = ~r.s2[1];
    assign rst_low_s = ~r.s2[2];

    // next-state logic
    always_comb
    begin
        logic stopped;
        logic deep_wake;
        logic ack;
        stopped = 1'b0;
        deep_wake = 1'b0;
        ack = 1'b0;
        next_r = r;
        next_r.ill = 1'b0;
        next_r.por = 1'b0;
        next_r.serr = 1'b0;
        next_r.sgrant = 1'b0;
        next_r.s1 = {reset_pin_n, irq_n_pin, wake_pin};
        next_r.s2 = r.s1;
        stopped = (r.mode != sps_pkg::SPS_RUN);

        // status commands: error while stopped, else granted
        if (dbg_status_cmd)
        begin
            next_r.serr = stopped;
            next_r.sgrant = ~stopped;
        end

        case (r.mode)
            sps_pkg::SPS_RUN:
            begin
                // stop is ignored while the debugger holds the core
                if (stop_exec && !r.dbg_act)
                begin
                    // illegal stop first, then debug or detector, then power-down bits
                    if (!r.stop_en)
                        next_r.ill = 1'b1;
                    else if (r.dbg_en || (r.lvd_en && r.lvd_stop) || !r.pd_ctl)
                        next_r.mode = sps_pkg::SPS_STOP3;
                    else if (r.part_pd)
                        next_r.mode = sps_pkg::SPS_STOP2;
                    else
                        next_r.mode = sps_pkg::SPS_STOP1;

                    // snapshot what must survive the stop period
                    next_r.lvd_hold = r.lvd_en & r.lvd_stop;
                    next_r.dbg_hold = r.dbg_en;

                    // only a true stop2 entry closes the pin latches
                    if (r.stop_en && r.pd_ctl && r.part_pd && !r.dbg_en && !(r.lvd_en && r.lvd_stop))
                    begin
                        next_r.latched = 1'b1;
                        next_r.lat_out = live[W-1:0];
                        next_r.lat_oe = live[2*W-1:W];
                    end
                end
            end
            sps_pkg::SPS_STOP3:
            begin
                // state kept; interrupts resume without reset
                if (stop3_irq || (r.rtien && rti_tick))
                    next_r.mode = sps_pkg::SPS_RUN;
                if (rst_low_s)
                begin
                    next_r.mode = sps_pkg::SPS_RUN;
                    next_r.por = 1'b1;
                end
            end
            sps_pkg::SPS_STOP2, sps_pkg::SPS_STOP1:
            begin
                // irq pin treated as active-low wake regardless of setup
                // no debug clock here: pins and tick are the only exits
                deep_wake = wake_s || irq_low_s || rst_low_s || (r.rtien && rti_tick);
            end
            default:
                next_r.mode = sps_pkg::SPS_RUN;
        endcase

        // debug background command wakes stop3 when enabled;
        // stop1 and stop2 have no debug clock to receive it
        if (dbg_background_cmd && r.dbg_en)
        begin
            next_r.dbg_act = 1'b1;
            if (r.mode == sps_pkg::SPS_STOP3)
                next_r.mode = sps_pkg::SPS_RUN;
        end

        // register writes take effect at the access edge
        if (access && pwrite && r.mode == sps_pkg::SPS_RUN)
        begin
            case (paddr)
                sps_pkg::ADDR_CTRL_ONE:
                begin
                    next_r.lvd_en = pwdata[sps_pkg::LVD_EN_BIT];
                    next_r.lvd_stop = pwdata[sps_pkg::LVD_STOP_BIT];
                    next_r.stop_en = pwdata[sps_pkg::STOP_EN_BIT];
                end

                sps_pkg::ADDR_CTRL_TWO:
                begin
                    next_r.part_pd = pwdata[sps_pkg::PART_PD_BIT];
                    next_r.pd_ctl = pwdata[sps_pkg::PD_CTL_BIT];
                    // acknowledge is a strobe, never stored, so it reads zero
                    ack = pwdata[sps_pkg::ACK_BIT];
                end

                sps_pkg::ADDR_CFG:
                begin
                    next_r.dbg_en = pwdata[sps_pkg::DBG_EN_BIT];
                    next_r.osc_stop = pwdata[sps_pkg::OSC_STOP_BIT];
                    next_r.lcd_stop3 = pwdata[sps_pkg::LCD_STOP3_BIT];
                    next_r.adack = pwdata[sps_pkg::ADACK_BIT];
                    next_r.rtien = pwdata[sps_pkg::RTIEN_BIT];
                    // clearing debug enable leaves background mode
                    if (!pwdata[sps_pkg::DBG_EN_BIT])
                        next_r.dbg_act = 1'b0;
                end
                sps_pkg::ADDR_PORT:
                begin
                    next_r.port_d = pwdata[W-1:0];
                    next_r.port_dd = pwdata[sps_pkg::PORT_DIR_LSB +: W];
                end
                default:
                    ;
            endcase
        end

        // acknowledge opens latches; pins follow live drive: peripheral where it owns the pin, else what ports now hold
        if (ack)
        begin
            // a zero written to the strobe never reaches here
            next_r.part_flag = 1'b0;
            next_r.pd_flag = 1'b0;
            next_r.latched = 1'b0;
        end

        // deep wake: power-on style reset of module registers, flags set
        if (deep_wake)
        begin
            next_r.mode = sps_pkg::SPS_RUN;
            next_r.por = 1'b1;

            // detector back on at its low trip point, as after power-on
            next_r.lvd_en = 1'b1;
            // every other control bit returns to its reset value
            next_r.lvd_stop = 1'b0;
            next_r.stop_en = 1'b0;
            next_r.part_pd = 1'b0;
            next_r.pd_ctl = 1'b0;
            next_r.dbg_en = 1'b0;
            next_r.osc_stop = 1'b0;
            next_r.lcd_stop3 = 1'b0;
            next_r.adack = 1'b0;
            next_r.rtien = 1'b0;
            next_r.dbg_act = 1'b0;
            next_r.port_d = sps_pkg::PORT_RESET;
            next_r.port_dd = sps_pkg::PORT_RESET;

            // stop2 kept ram, stop1 lost it: flags steer recovery
            next_r.part_flag = (r.mode == sps_pkg::SPS_STOP2);
            next_r.pd_flag = (r.mode == sps_pkg::SPS_STOP1);
        end

        // read data captured in setup so it stands during access
        next_r.rdata = '0;
        if (psel && !penable && !pwrite)
        begin
            case (paddr)
                sps_pkg::ADDR_CTRL_ONE:
                    next_r.rdata = {29'h0, r.stop_en, r.lvd_stop, r.lvd_en};
                // acknowledge slot always reads zero
                sps_pkg::ADDR_CTRL_TWO:
                    next_r.rdata = {27'h0, r.pd_flag, r.part_flag, 1'b0, r.pd_ctl, r.part_pd};
                sps_pkg::ADDR_CFG:
                    next_r.rdata = {27'h0, r.rtien, r.adack, r.lcd_stop3, r.osc_stop, r.dbg_en};
                sps_pkg::ADDR_STATUS:
                    next_r.rdata = {28'h0, r.latched, r.dbg_act, r.mode};
                sps_pkg::ADDR_PORT:
                    next_r.rdata = {16'h0, r.port_dd, r.port_d};
                default:
                    next_r.rdata = '0;
            endcase
        end
    end

    // single state register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            r <= '0;
            r.mode <= sps_pkg::SPS_RUN;
            // detector on out of reset, as after power-on
            r.lvd_en <= 1'b1;
            // irq and reset stages preset to their idle high; wake stage also preset high, but run mode ignores wake
            r.s1 <= 3'h7;
            r.s2 <= 3'h7;
        end
        else
            r <= next_r;
    end

    // apb answers with no wait state; unmapped reads zero, no error
    // writes are dropped while stopped: core clocks are halted
    // so software cannot race the wake-up reset
    assign pready = setup_ok;
    assign pslverr = 1'b0;
    assign prdata = r.rdata;

    // pulses, debug state and mode
    assign illegal_op_reset = r.ill;
    assign por_reset = r.por;
    assign dbg_status_err = r.serr;
    assign dbg_mem_grant = r.sgrant;
    assign dbg_active = r.dbg_act;
    assign stop_mode = r.mode;

    // power and clock gating per mode
    assign periph_clk_en = (r.mode == sps_pkg::SPS_RUN);
    assign dbg_clk_en = (r.mode == sps_pkg::SPS_RUN) || r.dbg_hold;
    assign reg_active = (r.mode == sps_pkg::SPS_RUN) || r.dbg_hold || r.lvd_hold;
    assign reg_standby = (r.mode == sps_pkg::SPS_STOP3 || r.mode == sps_pkg::SPS_STOP2) &&
                         !reg_active;
    assign ram_power = (r.mode != sps_pkg::SPS_STOP1);
    assign core_power = (r.mode == sps_pkg::SPS_RUN) || (r.mode == sps_pkg::SPS_STOP3);

    // stop3 options: each block idles unless its bit kept it
    assign adc_run = (r.mode == sps_pkg::SPS_RUN) ||
                     ((r.mode == sps_pkg::SPS_STOP3) && r.adack && r.lvd_hold);
    assign clkgen_run = (r.mode == sps_pkg::SPS_RUN) ||
                        ((r.mode == sps_pkg::SPS_STOP3) && r.osc_stop);
    assign lcd_run = (r.mode == sps_pkg::SPS_RUN) ||
                     ((r.mode == sps_pkg::SPS_STOP3) && r.lcd_stop3);

    // pins: high impedance in stop1, latched until ack, else live
    // stop1 pins float; otherwise latched or live drive
    assign pin_out = (r.mode == sps_pkg::SPS_STOP1) ? '0 :
                     (r.latched ? r.lat_out : live[W-1:0]);
    assign pin_oe_n = (r.mode == sps_pkg::SPS_STOP1) ? '1 :
                      ~(r.latched ? r.lat_oe : live[2*W-1:W]);

endmodule // sps_sequencer

//--- tb/sps_sequencer_sva.sv
`timescale 1ns/1ns
module sps_chk
(
    input wire logic pclk, // bus clock
    input wire logic presetn, // async reset
    input wire logic psel, // apb select
    input wire logic penable, // apb access
    input wire logic pwrite, // apb direction
    input wire logic [11:0] paddr, // apb address
    input wire logic [31:0] prdata, // apb read data
    input wire logic [1:0] stop_mode, // current mode
    input wire logic periph_clk_en, // peripheral clocks
    input wire logic [7:0] pin_out, // pin values
    input wire logic [7:0] pin_oe_n, // pin drive, low drives
    input wire logic ram_power, // ram supply
    input wire logic core_power, // main supply
    input wire logic dbg_status_cmd, // status command
    input wire logic dbg_status_err, // status error
    input wire logic dbg_mem_grant, // access granted
    input wire logic stop3_irq, // stop3 wake source
    input wire logic por_reset, // power-on style reset
    input wire logic irq_n_pin, // interrupt pin
    input wire logic dbg_clk_en, // debug clock
    input wire logic reg_active, // full regulation
    input wire logic reg_standby // regulator standby
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // irq held low long enough to clear the two-flop synchroniser
    sequence s_irq_held;
        (stop_mode[1] && !irq_n_pin) [*3];
    endsequence
    // a powered-down stop followed by run
    sequence s_deep_exit;
        stop_mode[1] ##1 stop_mode == 2'h0;
    endsequence
    // power, clocks and pins per stop level
    a_periph_clk_halt: assert property (stop_mode != 2'h0 |-> !periph_clk_en)
        else $error("peripheral clock runs while stopped");
    a_stop1_power_off: assert property (stop_mode == 2'h3 |-> !ram_power && !core_power && pin_oe_n == 8'hff)
        else $error("stop1 leaves power or pin drive on");
    a_stop2_ram_kept: assert property (stop_mode == 2'h2 |-> ram_power && !core_power)
        else $error("stop2 power state wrong");
    a_stop2_pins_held: assert property (stop_mode == 2'h2 && $past(stop_mode) == 2'h2
        |-> $stable(pin_out) && $stable(pin_oe_n))
        else $error("pins moved during stop2");
    a_dbg_full_reg: assert property (stop_mode != 2'h0 && dbg_clk_en |-> reg_active && !reg_standby)
        else $error("regulator dropped with debug clock on");
    // debug and wake behaviour
    a_status_err_stop: assert property (stop_mode != 2'h0 && dbg_status_cmd |=> dbg_status_err && !dbg_mem_grant)
        else $error("status command not refused in stop");
    a_stop3_irq_exit: assert property (stop_mode == 2'h1 && stop3_irq |=> stop_mode == 2'h0)
        else $error("stop3 interrupt did not wake");
    a_deep_wake_por: assert property (s_deep_exit |-> por_reset)
        else $error("deep wake without power-on reset");
    a_irq_low_wake: assert property (s_irq_held |-> ##[1:2] stop_mode == 2'h0)
        else $error("low irq did not wake");
    a_ack_reads_zero: assert property (psel && penable && !pwrite && paddr == sps_pkg::ADDR_CTRL_TWO
        |-> !prdata[sps_pkg::ACK_BIT])
        else $error("acknowledge bit reads one");
endmodule // sps_chk

bind sps_sequencer sps_chk i_sps_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .prdata, .stop_mode,
    .periph_clk_en, .pin_out, .pin_oe_n, .ram_power, .core_power, .dbg_status_cmd, .dbg_status_err,
    .dbg_mem_grant, .stop3_irq, .por_reset, .irq_n_pin, .dbg_clk_en, .reg_active, .reg_standby);

//--- tb/sps_far_side.sv
`timescale 1ns/1ns
module sps_far_side
(
    input wire logic pclk, // bus clock
    output logic wake_pin, // wake pin, pulled low
    output logic irq_n_pin, // interrupt pin, pulled high
    output logic reset_pin_n, // reset pin, pulled high
    output logic dbg_background_cmd, // debug host command
    output logic dbg_status_cmd // debug host status command
);
    // pulled levels while nobody drives
    initial
    begin
        wake_pin = 1'b0;
        irq_n_pin = 1'b1;
        reset_pin_n = 1'b1;
        dbg_background_cmd = 1'b0;
        dbg_status_cmd = 1'b0;
    end
    // hold one wake source; must outlast the synchroniser
    task automatic hold(input int k, input int n);
        @(posedge pclk);
        if (k == 0)
            wake_pin <= 1'b1;
        else if (k == 1)
            irq_n_pin <= 1'b0;
        else
            reset_pin_n <= 1'b0;
        repeat (n) @(posedge pclk);
        wake_pin <= 1'b0;
        irq_n_pin <= 1'b1;
        reset_pin_n <= 1'b1;
    endtask
    // one-cycle debug command
    task automatic cmd(input logic bg);
        @(posedge pclk);
        dbg_background_cmd <= bg;
        dbg_status_cmd <= !bg;
        @(posedge pclk);
        dbg_background_cmd <= 1'b0;
        dbg_status_cmd <= 1'b0;
    endtask
endmodule // sps_far_side

//--- tb/sps_sequencer_tb.sv
`timescale 1ns/1ns
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin n_fail++; $display("[FAIL] %0t %h %h", $time, a, b); end end
module sps_sequencer_tb;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, stop_exec = 1'b0, rti_tick = 1'b0, stop3_irq = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [7:0] periph_en = 8'h00, periph_out = 8'h00, periph_oe = 8'h00, pin_out, pin_oe_n;
    logic [1:0] stop_mode;
    logic pready, pslverr, wake_pin, irq_n_pin, reset_pin_n, dbg_background_cmd, dbg_status_cmd;
    logic illegal_op_reset, por_reset, dbg_status_err, dbg_mem_grant, dbg_active, dbg_clk_en, periph_clk_en;
    logic reg_active, reg_standby, ram_power, core_power, adc_run, clkgen_run, lcd_run;
    int n_fail = 0, total_checks = 0, cyc = 0, n_ill = 0, por = 0;
    sps_sequencer i_sps_sequencer (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .stop_exec, .wake_pin, .irq_n_pin, .reset_pin_n, .rti_tick, .stop3_irq, .dbg_background_cmd,
        .dbg_status_cmd, .periph_en, .periph_out, .periph_oe, .illegal_op_reset, .por_reset, .dbg_status_err,
        .dbg_mem_grant, .dbg_active, .dbg_clk_en, .periph_clk_en, .reg_active, .reg_standby, .ram_power,
        .core_power, .adc_run, .clkgen_run, .lcd_run, .stop_mode, .pin_out, .pin_oe_n);
    sps_far_side i_sps_far_side (.pclk, .wake_pin, .irq_n_pin, .reset_pin_n, .dbg_background_cmd, .dbg_status_cmd);
    always #2 pclk = ~pclk;
    task automatic finish_test();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // hang guard, far above the run length
    always @(posedge pclk)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            n_fail++;
            finish_test();
        end
    end
    // one apb transfer; read data taken at the ready edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        #1;
    endtask
    task automatic rchk(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        `CHK(rd, e)
    endtask
    // stop instruction, counting illegal-op resets seen after it
    task automatic do_stop();
        @(posedge pclk);
        stop_exec <= 1'b1;
        @(posedge pclk);
        stop_exec <= 1'b0;
        n_ill = 0;
        repeat (3)
        begin
            #1;
            if (illegal_op_reset === 1'b1)
                n_ill++;
            @(posedge pclk);
        end
        #1;
    endtask
    // wait for run; internal wake pulses last one cycle only
    task automatic wait_run();
        por = 0;
        repeat (20)
        begin
            @(posedge pclk);
            stop3_irq <= 1'b0;
            rti_tick <= 1'b0;
            #1;
            if (por_reset === 1'b1)
                por = 1;
            if (stop_mode === 2'h0)
                break;
        end
    endtask
    initial
    begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        rchk(sps_pkg::ADDR_CTRL_ONE, 32'h1);
        rchk(sps_pkg::ADDR_CTRL_TWO, 32'h0);
        rchk(12'h020, 32'h0);
        do_stop();
        `CHK({n_ill, stop_mode}, {32'h1, 2'h0})
        // stop3 with and without the optional blocks kept alive
        for (int i = 0; i < 2; i++)
        begin
            apb(1'b1, sps_pkg::ADDR_CTRL_ONE, i ? 32'h5 : 32'h7);
            apb(1'b1, sps_pkg::ADDR_CFG, i ? 32'h10 : 32'h0e);
            do_stop();
            `CHK({stop_mode, periph_clk_en}, 3'h2)
            `CHK({reg_active, reg_standby}, i ? 2'h1 : 2'h2)
            `CHK({adc_run, clkgen_run, lcd_run}, i ? 3'h0 : 3'h7)
            i_sps_far_side.cmd(1'b0);
            #1;
            `CHK(dbg_status_err, 1'b1)
            apb(1'b1, sps_pkg::ADDR_CFG, 32'h0);
            @(posedge pclk);
            stop3_irq <= !i;
            rti_tick <= i[0];
            wait_run();
            `CHK({stop_mode, por[0]}, 3'h0)
            rchk(sps_pkg::ADDR_CFG, i ? 32'h10 : 32'h0e);
        end
        // debug enabled overrides the power-down choice
        apb(1'b1, sps_pkg::ADDR_CFG, 32'h1);
        apb(1'b1, sps_pkg::ADDR_CTRL_TWO, 32'h2);
        do_stop();
        `CHK({stop_mode, dbg_clk_en, reg_active, periph_clk_en}, 5'h0e)
        i_sps_far_side.cmd(1'b1);
        #1;
        `CHK({dbg_active, stop_mode}, 3'h4)
        i_sps_far_side.cmd(1'b0);
        #1;
        `CHK(dbg_mem_grant, 1'b1)
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        // stop2 with wake pin and irq, then stop1 with irq, reset and periodic wakes
        for (int i = 0; i < 5; i++)
        begin
            apb(1'b1, sps_pkg::ADDR_CTRL_ONE, 32'h5);
            apb(1'b1, sps_pkg::ADDR_CFG, {27'h0, i == 4, 4'h0});
            apb(1'b1, sps_pkg::ADDR_PORT, 32'hffa5);
            apb(1'b1, sps_pkg::ADDR_CTRL_TWO, i < 2 ? 32'h3 : 32'h2);
            do_stop();
            @(posedge pclk);
            periph_en <= 8'hff;
            periph_out <= 8'h3c;
            periph_oe <= 8'hff;
            @(posedge pclk);
            #1;
            `CHK(stop_mode, i < 2 ? 2'h2 : 2'h3)
            `CHK({ram_power, core_power}, i < 2 ? 2'h2 : 2'h0)
            `CHK(pin_oe_n, i < 2 ? 8'h00 : 8'hff)
            if (i < 2) `CHK(pin_out, 8'ha5)
            @(posedge pclk);
            rti_tick <= (i == 4);
            fork
                if (i < 4) i_sps_far_side.hold(i < 2 ? i : i - 1, 4);
                wait_run();
            join
            `CHK({stop_mode, por[0]}, 3'h1)
            rchk(sps_pkg::ADDR_CTRL_ONE, 32'h1);
            rchk(sps_pkg::ADDR_CTRL_TWO, i < 2 ? 32'h08 : 32'h10);
            apb(1'b1, sps_pkg::ADDR_CTRL_TWO, 32'h0);
            rchk(sps_pkg::ADDR_CTRL_TWO, i < 2 ? 32'h08 : 32'h10);
            if (i < 2) `CHK({pin_out, pin_oe_n}, 16'ha500)
            @(posedge pclk);
            periph_en <= (i == 0) ? 8'h80 : 8'h00;
            periph_out <= 8'h80;
            periph_oe <= 8'h80;
            if (i == 0) apb(1'b1, sps_pkg::ADDR_PORT, 32'hff5a);
            apb(1'b1, sps_pkg::ADDR_CTRL_TWO, 32'h4);
            rchk(sps_pkg::ADDR_CTRL_TWO, 32'h0);
            if (i < 2) `CHK(pin_oe_n, i ? 8'hff : 8'h00)
            if (i == 0) `CHK(pin_out, 8'hda)
        end
        finish_test();
    end
endmodule // sps_sequencer_tb
